//--- dn_link_checker.sv
// checker for the frame link between the master and slave ends
`timescale 1ns/100ps
`default_nettype none
module dn_link_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  node_addr,
  input wire logic        m2s_valid,
  input wire logic        m2s_ready,
  input wire logic [10:0] m2s_id,
  input wire logic [7:0]  m2s_data,
  input wire logic        m2s_last,
  input wire logic        s2m_valid,
  input wire logic        s2m_ready,
  input wire logic [10:0] s2m_id,
  input wire logic [7:0]  s2m_data,
  input wire logic        s2m_last
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire take_last = m2s_valid && m2s_ready && m2s_last;
  wire own       = m2s_id[8:3] == node_addr;
  property p_m2s_hold;
    m2s_valid && !m2s_ready |=> m2s_valid && $stable(m2s_id) && $stable(m2s_data)
      && $stable(m2s_last);
  endproperty
  a_m2s_hold: assert property (p_m2s_hold)
    else $error("m2s beat changed before it was taken");
  property p_s2m_hold;
    s2m_valid && !s2m_ready |=> s2m_valid && $stable(s2m_id) && $stable(s2m_data)
      && $stable(s2m_last);
  endproperty
  a_s2m_hold: assert property (p_s2m_hold)
    else $error("s2m beat changed before it was taken");
  property p_m2s_prefix;
    m2s_valid |-> m2s_id[10:9] == 2'h2;
  endproperty
  a_m2s_prefix: assert property (p_m2s_prefix)
    else $error("master frame without group 2 prefix");
  property p_s2m_form;
    s2m_valid |-> s2m_id == {2'h2, node_addr, 3'h3} || (s2m_id[5:0] == node_addr
      && s2m_id[10:6] inside {5'h0D, 5'h0E, 5'h0F});
  endproperty
  a_s2m_form: assert property (p_s2m_form)
    else $error("slave answer with a foreign identifier");
  // one frame at a time: taking input while answering would break ordering
  property p_busy;
    s2m_valid |-> !m2s_ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("slave took a beat while answering");
  property p_uncon;
    take_last && own && m2s_id[2:0] == 3'h6 |=> !s2m_valid ##[1:2] s2m_valid;
  endproperty
  a_uncon: assert property (p_uncon)
    else $error("unconnected request not answered in time");
  property p_dup;
    take_last && own && m2s_id[2:0] == 3'h7 |=> !s2m_valid [*4];
  endproperty
  a_dup: assert property (p_dup)
    else $error("duplicate check frame was answered");
  property p_foreign;
    take_last && !own && m2s_id[2:0] != 3'h0 |=> !s2m_valid [*4];
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("frame for another node was answered");
endmodule
`default_nettype wire

//--- dn_link_if.sv
// frame link between master and slave, one byte per beat
`timescale 1ns/100ps
`default_nettype none
interface dn_link_if;
  logic        m2s_valid;
  logic        m2s_ready;
  logic [10:0] m2s_id;
  logic [7:0]  m2s_data;
  logic        m2s_last;
  logic        s2m_valid;
  logic        s2m_ready;
  logic [10:0] s2m_id;
  logic [7:0]  s2m_data;
  logic        s2m_last;

  modport slave (
    input  m2s_valid, m2s_id, m2s_data, m2s_last, s2m_ready,
    output m2s_ready, s2m_valid, s2m_id, s2m_data, s2m_last
  );
  modport master (
    output m2s_valid, m2s_id, m2s_data, m2s_last, s2m_ready,
    input  m2s_ready, s2m_valid, s2m_id, s2m_data, s2m_last
  );
endinterface
`default_nettype wire

//--- dn_master_end.sv
// master end: builds group 2 identifiers and holds one beat each way
`timescale 1ns/100ps
`default_nettype none
module dn_master_end (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  dn_link_if.master        lnk,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [5:0]  tx_node,
  input  wire logic [2:0]  tx_code,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [10:0]      rx_id,
  output logic [7:0]       rx_data,
  output logic             rx_last
);
  // one-beat holding stages; half rate, traded for registered ready outputs
  logic        m_valid_q, m_last_q, tx_ready_q, s_ready_q, r_valid_q, r_last_q;
  logic [10:0] m_id_q, r_id_q;
  logic [7:0]  m_data_q, r_data_q;

  wire load_tx  = tx_valid && tx_ready_q;
  wire drain_tx = m_valid_q && lnk.m2s_ready;
  wire mfull_d  = load_tx || (m_valid_q && !drain_tx);
  wire load_rx  = lnk.s2m_valid && s_ready_q;
  wire drain_rx = r_valid_q && rx_ready;
  wire rfull_d  = load_rx || (r_valid_q && !drain_rx);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_valid_q  <= 1'b0;
      m_last_q   <= 1'b0;
      m_id_q     <= 11'h000;
      m_data_q   <= 8'h00;
      tx_ready_q <= 1'b0;
    end else begin
      m_valid_q  <= mfull_d;
      tx_ready_q <= !mfull_d;
      if (load_tx) begin
        m_id_q   <= {dn_pkg::GRP2_PREFIX, tx_node, tx_code};  // [R6] [R7] [R8] [R9]
        m_data_q <= tx_data;
        m_last_q <= tx_last;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_valid_q <= 1'b0;
      r_last_q  <= 1'b0;
      r_id_q    <= 11'h000;
      r_data_q  <= 8'h00;
      s_ready_q <= 1'b0;
    end else begin
      r_valid_q <= rfull_d;
      s_ready_q <= !rfull_d;
      if (load_rx) begin
        r_id_q   <= lnk.s2m_id;
        r_data_q <= lnk.s2m_data;
        r_last_q <= lnk.s2m_last;
      end
    end
  end

  assign lnk.m2s_valid = m_valid_q;
  assign lnk.m2s_id    = m_id_q;
  assign lnk.m2s_data  = m_data_q;
  assign lnk.m2s_last  = m_last_q;
  assign lnk.s2m_ready = s_ready_q;
  assign tx_ready      = tx_ready_q;
  assign rx_valid      = r_valid_q;
  assign rx_id         = r_id_q;
  assign rx_data       = r_data_q;
  assign rx_last       = r_last_q;
endmodule
`default_nettype wire

//--- dn_pkg.sv
// shared constants for the group 2 slave link, both ends
package dn_pkg;
  // identifier layout: prefix(2) node(6) message code(3)
  localparam logic [1:0] GRP2_PREFIX   = 2'h2;
  localparam logic [2:0] MSG_DUP       = 3'h7;
  localparam logic [2:0] MSG_UNCON     = 3'h6;
  localparam logic [2:0] MSG_POLL      = 3'h5;
  localparam logic [2:0] MSG_EXPL      = 3'h4;
  localparam logic [2:0] MSG_EXP_RESP  = 3'h3;
  localparam logic [2:0] MSG_STROBE    = 3'h0;
  // group 1 response prefixes, followed by the node address
  localparam logic [4:0] G1_COS        = 5'h0D;
  localparam logic [4:0] G1_STROBE     = 5'h0E;
  localparam logic [4:0] G1_POLL       = 5'h0F;
  // services
  localparam logic [7:0] SVC_GET       = 8'h0E;
  localparam logic [7:0] SVC_SET       = 8'h10;
  localparam logic [7:0] SVC_ALLOC     = 8'h4B;
  localparam logic [7:0] SVC_RELEASE   = 8'h4C;
  localparam logic [7:0] SVC_RESP_BIT  = 8'h80;
  localparam logic [7:0] SVC_ERR       = 8'h94;
  // general error codes and the empty extended code
  localparam logic [7:0] ERR_NONE      = 8'h00;
  localparam logic [7:0] ERR_SVC       = 8'h08;
  localparam logic [7:0] ERR_VALUE     = 8'h09;
  localparam logic [7:0] ERR_ATTR      = 8'h14;
  localparam logic [7:0] ERR_OBJ       = 8'h16;
  localparam logic [7:0] ERR_EXT_NONE  = 8'hFF;
  // object classes, instances, attributes
  localparam logic [7:0] CLS_IDENTITY  = 8'h01;
  localparam logic [7:0] CLS_NETWORK   = 8'h03;
  localparam logic [7:0] CLS_CONN      = 8'h05;
  localparam logic [7:0] CLS_CONSUMED  = 8'h64;
  localparam logic [7:0] CLS_PRODUCED  = 8'h65;
  localparam logic [7:0] INST_CLASS    = 8'h00;
  localparam logic [7:0] INST_ONE      = 8'h01;
  localparam logic [7:0] ATTR_REV      = 8'h01;
  localparam logic [7:0] ATTR_PRODUCT  = 8'h03;
  localparam logic [7:0] ATTR_MACID    = 8'h01;
  localparam logic [7:0] ATTR_ALLOC    = 8'h01;
  localparam logic [7:0] ATTR_SIZE     = 8'h03;
  localparam logic [7:0] CLASS_REV     = 8'h01;
  // allocation choice bits
  localparam int         ALLOC_EXPL    = 0;
  localparam int         ALLOC_POLL    = 1;
  localparam int         ALLOC_STROBE  = 2;
  localparam int         ALLOC_COS     = 4;
  localparam logic [7:0] ALLOC_MASK    = 8'h17;
  // request byte positions within an explicit frame
  localparam logic [2:0] B_SVC         = 3'h1;
  localparam logic [2:0] B_CLASS       = 3'h2;
  localparam logic [2:0] B_INST        = 3'h3;
  localparam logic [2:0] B_ATTR        = 3'h4;
  localparam logic [2:0] B_VAL         = 3'h5;
  localparam int         HDR_BYTES     = 8;
  // i/o sizes
  localparam logic [7:0] SIZE_MIN      = 8'h01;
  localparam logic [7:0] SIZE_MAX      = 8'hFF;
  localparam logic [7:0] SIZE_RESET    = 8'h08;
  localparam int         FIFO_DEPTH    = 16;
  localparam int         PROD_BYTES    = 255;

  typedef enum logic [2:0] {
    K_NONE, K_DUP, K_UNCON, K_POLL, K_EXPL, K_STROBE
  } kind_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h1,
    ST_EXEC     = 4'h2,
    ST_SEND_EXP = 4'h4,
    ST_SEND_IO  = 4'h8
  } state_t;
endpackage

//--- dn_slave_end.sv
// slave end: identifier filter, service executor, i/o producer, consumed-data fifo
`timescale 1ns/100ps
`default_nettype none
module dn_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = dn_pkg::FIFO_DEPTH
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [WIDTH-1:0]       in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [WIDTH-1:0]            out_data,
  output logic [$clog2(DEPTH):0]      level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              do_push = in_valid && in_ready;
  wire              do_pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;

  always_ff @(posedge ref_clk) begin
    if (do_push) mem[wr_q] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// How it works
// [R1] identity instance 1 attribute 3 returns product code
// [R2] group 2 slave, predefined set only
// [R3] poll, change-of-state and bit-strobe i/o supported
// [R4] unconnected requests: only allocate and release
// [R5] consumed and produced sizes independently 1 to 255
// [R6] 10, own node, 111 is duplicate check
// [R7] 10, own node, 110 is unconnected request
// [R8] 10, own node, 101 is poll command
// [R9] 10, own node, 100 is explicit request
// [R10] middle six identifier bits compared with node
// [R11] get 0E and set 10, class and instance; set is accepted on instance 1 only, class-level set gets error 14
// [R12] allocate on 4B, release on 4C
// [R13] classes 01, 03, 05, 64, 65 answered
// [R14] foreign or unknown identifiers ignored silently
// [R15] unknown service or class gets error response
module dn_slave_end (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  dn_link_if.slave         lnk,
  input  wire logic [5:0]  node_addr,
  input  wire logic [15:0] product_code,
  input  wire logic        prod_wr,
  input  wire logic [7:0]  prod_addr,
  input  wire logic [7:0]  prod_wdata,
  input  wire logic        cos_trig,
  output logic             cons_valid,
  input  wire logic        cons_ready,
  output logic [7:0]       cons_data,
  output logic             dup_detect,
  output logic [7:0]       alloc_state
);
  localparam int LW = $clog2(dn_pkg::FIFO_DEPTH) + 1;

  function automatic dn_pkg::kind_t classify(input logic [10:0] id, input logic [5:0] node,
                                              input logic [7:0] alloc);
    classify = dn_pkg::K_NONE;                                             // [R14]
    if (id[10:9] == dn_pkg::GRP2_PREFIX && id[8:3] == node) begin          // [R10]
      case (id[2:0])
        dn_pkg::MSG_DUP:   classify = dn_pkg::K_DUP;                       // [R6]
        dn_pkg::MSG_UNCON: classify = dn_pkg::K_UNCON;                     // [R7]
        dn_pkg::MSG_POLL:  if (alloc[dn_pkg::ALLOC_POLL]) classify = dn_pkg::K_POLL;  // [R8]
        dn_pkg::MSG_EXPL:  if (alloc[dn_pkg::ALLOC_EXPL]) classify = dn_pkg::K_EXPL;  // [R9]
        default:           classify = dn_pkg::K_NONE;
      endcase
    end else if (id[10:9] == dn_pkg::GRP2_PREFIX && id[2:0] == dn_pkg::MSG_STROBE
                 && alloc[dn_pkg::ALLOC_STROBE]) begin
      classify = dn_pkg::K_STROBE;  // strobe carries the master's address [R3]
    end
  endfunction

  // {ok, two bytes, data}
  function automatic logic [17:0] get_attr(input logic [7:0] cls, input logic [7:0] inst,
                                           input logic [7:0] attr, input logic [15:0] pcode,
                                           input logic [5:0] node, input logic [7:0] alloc,
                                           input logic [7:0] csz, input logic [7:0] psz);
    get_attr = '0;
    if (inst == dn_pkg::INST_CLASS && attr == dn_pkg::ATTR_REV) begin
      get_attr = {2'h2, 8'h00, dn_pkg::CLASS_REV};                         // [R11]
    end else if (inst == dn_pkg::INST_ONE) begin
      case (cls)
        dn_pkg::CLS_IDENTITY: if (attr == dn_pkg::ATTR_PRODUCT) get_attr = {2'h3, pcode}; // [R1]
        dn_pkg::CLS_NETWORK:  if (attr == dn_pkg::ATTR_MACID) get_attr = {2'h2, 10'h000, node};
        dn_pkg::CLS_CONN:     if (attr == dn_pkg::ATTR_ALLOC) get_attr = {2'h2, 8'h00, alloc};
        dn_pkg::CLS_CONSUMED: if (attr == dn_pkg::ATTR_SIZE) get_attr = {2'h2, 8'h00, csz};
        dn_pkg::CLS_PRODUCED: if (attr == dn_pkg::ATTR_SIZE) get_attr = {2'h2, 8'h00, psz};
        default:              get_attr = '0;
      endcase
    end
  endfunction

  dn_pkg::state_t state_q, state_d;
  dn_pkg::kind_t  kind_q;
  logic [7:0]     hdr_q [0:dn_pkg::HDR_BYTES-1];
  logic [7:0]     tx_q [0:3];
  logic [7:0]     prod_mem [0:dn_pkg::PROD_BYTES-1];
  logic [7:0]     bcnt_q, idx_q, alloc_q, cons_size_q, prod_size_q;
  logic [2:0]     tx_len_q;
  logic           m2s_ready_q, s2m_valid_q, s2m_last_q, cos_pend_q, dup_q;
  logic [10:0]    s2m_id_q;
  logic [7:0]     s2m_data_q;
  logic [LW-1:0]  fifo_level;
  logic           fifo_in_ready;

  // receive side
  wire            acc      = lnk.m2s_valid && m2s_ready_q;
  wire            first    = (bcnt_q == 8'h00);
  wire dn_pkg::kind_t kind_now = first ? classify(lnk.m2s_id, node_addr, alloc_q) : kind_q;
  wire            end_frm  = acc && lnk.m2s_last;
  wire            push     = acc && kind_now == dn_pkg::K_POLL
                             && bcnt_q < cons_size_q && fifo_in_ready; // extra bytes dropped [R5]
  wire            go_exec  = end_frm && (kind_now == dn_pkg::K_EXPL || kind_now == dn_pkg::K_UNCON);
  wire            go_io    = end_frm && (kind_now == dn_pkg::K_POLL || kind_now == dn_pkg::K_STROBE);
  // change of state waits for a gap between incoming frames
  wire            cos_go   = state_q == dn_pkg::ST_IDLE && first && !acc && cos_pend_q
                             && alloc_q[dn_pkg::ALLOC_COS];                // [R3]
  wire            room     = ({1'b0, fifo_level} + (LW+1)'(push)) < (LW+1)'(dn_pkg::FIFO_DEPTH);

  // executor
  wire [7:0]  svc      = hdr_q[dn_pkg::B_SVC];
  wire [7:0]  cls      = hdr_q[dn_pkg::B_CLASS];
  wire [7:0]  inst     = hdr_q[dn_pkg::B_INST];
  wire [7:0]  attr     = hdr_q[dn_pkg::B_ATTR];
  wire [7:0]  val      = hdr_q[dn_pkg::B_VAL];
  wire        svc_attr = svc == dn_pkg::SVC_GET || svc == dn_pkg::SVC_SET;           // [R11]
  wire        svc_conn = svc == dn_pkg::SVC_ALLOC || svc == dn_pkg::SVC_RELEASE;     // [R12]
  wire        cls_ok   = cls == dn_pkg::CLS_IDENTITY || cls == dn_pkg::CLS_NETWORK
                         || cls == dn_pkg::CLS_CONN || cls == dn_pkg::CLS_CONSUMED
                         || cls == dn_pkg::CLS_PRODUCED;                             // [R13]
  wire [17:0] g        = get_attr(cls, inst, attr, product_code, node_addr, alloc_q,
                                  cons_size_q, prod_size_q);
  wire        set_attr = inst == dn_pkg::INST_ONE && attr == dn_pkg::ATTR_SIZE
                         && (cls == dn_pkg::CLS_CONSUMED || cls == dn_pkg::CLS_PRODUCED);
  wire        set_ok   = set_attr && val >= dn_pkg::SIZE_MIN && val <= dn_pkg::SIZE_MAX; // [R5]
  wire [7:0]  err      = (kind_q == dn_pkg::K_UNCON && !svc_conn) ? dn_pkg::ERR_SVC  // [R4]
                       : (!svc_attr && !svc_conn) ? dn_pkg::ERR_SVC                  // [R15]
                       : (svc_conn && cls != dn_pkg::CLS_NETWORK) ? dn_pkg::ERR_OBJ
                       : (svc_attr && !cls_ok) ? dn_pkg::ERR_OBJ                     // [R15]
                       : (svc == dn_pkg::SVC_GET && !g[17]) ? dn_pkg::ERR_ATTR
                       : (svc == dn_pkg::SVC_SET && !set_ok)
                         ? (set_attr ? dn_pkg::ERR_VALUE : dn_pkg::ERR_ATTR)
                       : dn_pkg::ERR_NONE;
  wire        has_err  = err != dn_pkg::ERR_NONE;
  wire [7:0]  resp1    = has_err ? dn_pkg::SVC_ERR : (svc | dn_pkg::SVC_RESP_BIT);
  wire [7:0]  resp2    = has_err ? err : (svc == dn_pkg::SVC_GET) ? g[7:0] : 8'h00;
  wire [7:0]  resp3    = has_err ? dn_pkg::ERR_EXT_NONE : g[15:8];
  wire [2:0]  resp_len = has_err ? 3'h4 : (svc == dn_pkg::SVC_GET) ? (g[16] ? 3'h4 : 3'h3)
                       : svc_conn ? 3'h3 : 3'h2;
  wire [7:0]  choice   = attr & dn_pkg::ALLOC_MASK;  // allocation choice sits in byte 4

  // transmit side
  wire        tx_acc   = s2m_valid_q && lnk.s2m_ready;
  wire        in_exp   = state_q == dn_pkg::ST_SEND_EXP;
  wire [7:0]  nxt_idx  = idx_q + 8'h01;
  wire [7:0]  nxt_byte = in_exp ? tx_q[nxt_idx[1:0]] : prod_mem[nxt_idx];
  wire [7:0]  last_at  = in_exp ? {5'h00, tx_len_q} - 8'h01 : prod_size_q - 8'h01;
  wire [4:0]  io_pfx   = cos_go ? dn_pkg::G1_COS
                       : (kind_now == dn_pkg::K_STROBE) ? dn_pkg::G1_STROBE : dn_pkg::G1_POLL;

  always_comb begin
    state_d = state_q;
    case (state_q)
      dn_pkg::ST_IDLE: begin
        if (go_exec) state_d = dn_pkg::ST_EXEC;
        else if (go_io || cos_go) state_d = dn_pkg::ST_SEND_IO;
      end
      dn_pkg::ST_EXEC:     state_d = dn_pkg::ST_SEND_EXP;
      dn_pkg::ST_SEND_EXP,
      dn_pkg::ST_SEND_IO: if (tx_acc && s2m_last_q) state_d = dn_pkg::ST_IDLE;
      default:             state_d = dn_pkg::ST_IDLE;
    endcase
  end

  dn_byte_fifo #(.WIDTH(8), .DEPTH(dn_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (lnk.m2s_data),
    .out_valid (cons_valid),
    .out_ready (cons_ready),
    .out_data  (cons_data),
    .level     (fifo_level)
  );

  // produced image; rewriting it during a send mixes old and new bytes
  always_ff @(posedge ref_clk) begin
    if (prod_wr && prod_addr < 8'(dn_pkg::PROD_BYTES)) prod_mem[prod_addr] <= prod_wdata;
    if (acc && bcnt_q < 8'(dn_pkg::HDR_BYTES)) hdr_q[bcnt_q[2:0]] <= lnk.m2s_data;
    if (state_q == dn_pkg::ST_EXEC) tx_q <= '{hdr_q[0], resp1, resp2, resp3};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= dn_pkg::ST_IDLE;
      kind_q      <= dn_pkg::K_NONE;
      bcnt_q      <= 8'h00;
      m2s_ready_q <= 1'b0;
      alloc_q     <= 8'h00;
      cons_size_q <= dn_pkg::SIZE_RESET;
      prod_size_q <= dn_pkg::SIZE_RESET;
      cos_pend_q  <= 1'b0;
      dup_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      m2s_ready_q <= state_d == dn_pkg::ST_IDLE && room;  // stalls the master when fifo fills
      if (acc) begin
        bcnt_q <= lnk.m2s_last ? 8'h00 : (bcnt_q == 8'hFF ? bcnt_q : bcnt_q + 8'h01);
        if (first) kind_q <= kind_now;
        if (first && kind_now == dn_pkg::K_DUP) dup_q <= 1'b1;  // [R6]
      end
      cos_pend_q <= cos_trig || (cos_pend_q && !cos_go);  // a new trigger beats the clear
      if (state_q == dn_pkg::ST_EXEC && !has_err) begin
        if (svc == dn_pkg::SVC_SET && cls == dn_pkg::CLS_CONSUMED) cons_size_q <= val; // [R5]
        if (svc == dn_pkg::SVC_SET && cls == dn_pkg::CLS_PRODUCED) prod_size_q <= val; // [R5]
        if (svc == dn_pkg::SVC_ALLOC) alloc_q <= alloc_q | choice;                   // [R12]
        if (svc == dn_pkg::SVC_RELEASE) alloc_q <= alloc_q & ~choice;                // [R12]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s2m_valid_q <= 1'b0;
      s2m_last_q  <= 1'b0;
      s2m_id_q    <= 11'h000;
      s2m_data_q  <= 8'h00;
      idx_q       <= 8'h00;
      tx_len_q    <= 3'h0;
    end else if (state_q == dn_pkg::ST_EXEC) begin
      s2m_valid_q <= 1'b1;
      s2m_last_q  <= 1'b0;
      s2m_id_q    <= {dn_pkg::GRP2_PREFIX, node_addr, dn_pkg::MSG_EXP_RESP};  // [R2]
      s2m_data_q  <= hdr_q[0];
      idx_q       <= 8'h00;
      tx_len_q    <= resp_len;
    end else if (state_q == dn_pkg::ST_IDLE && (go_io || cos_go) && !go_exec) begin
      s2m_valid_q <= 1'b1;                                                    // [R3]
      s2m_last_q  <= prod_size_q == dn_pkg::SIZE_MIN;
      s2m_id_q    <= {io_pfx, node_addr};
      s2m_data_q  <= prod_mem[0];
      idx_q       <= 8'h00;
    end else if (tx_acc) begin
      s2m_valid_q <= !s2m_last_q;
      s2m_last_q  <= nxt_idx == last_at;
      s2m_data_q  <= nxt_byte;
      idx_q       <= nxt_idx;
    end
  end

  assign lnk.m2s_ready = m2s_ready_q;
  assign lnk.s2m_valid = s2m_valid_q;
  assign lnk.s2m_last  = s2m_last_q;
  assign lnk.s2m_id    = s2m_id_q;
  assign lnk.s2m_data  = s2m_data_q;
  assign dup_detect    = dup_q;
  assign alloc_state   = alloc_q;
endmodule
`default_nettype wire

//--- tb_devicenet_group2_slave_handler.sv
// testbench: master and slave ends joined by the link, table of explicit requests
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb_devicenet_group2_slave_handler;
  typedef struct packed {
    logic [2:0] code; logic [5:0] nd; logic [2:0] n; logic [39:0] req;
    logic [1:0] m; logic [23:0] rsp;
  } row_t;
  logic ref_clk, rst_n, prod_wr, cos_trig, cons_ready, tx_valid, tx_last;
  logic [7:0] prod_addr, prod_wdata, tx_data;
  logic [5:0] tx_node;
  logic [2:0] tx_code;
  logic cons_valid, dup_detect, tx_ready, rx_valid, rx_last;
  logic [7:0] cons_data, alloc_state, rx_data;
  logic [10:0] rx_id;
  logic [19:0] rxq [$];
  logic [7:0] consq [$];
  int num_errors = 0, cmp_count = 0, pc = 0;
  // header byte 05 is sent ahead of every row; answers echo it first
  row_t rows [19] = '{
    {3'h4, 6'h2A, 3'h4, 40'h0E01010300, 2'h0, 24'h0},
    {3'h6, 6'h2A, 3'h4, 40'h4B03011700, 2'h2, 24'hCB0000},
    {3'h6, 6'h2A, 3'h4, 40'h0E01010300, 2'h3, 24'h9408FF},
    {3'h4, 6'h2A, 3'h4, 40'h0E01010300, 2'h3, 24'h8EC3A5},
    {3'h4, 6'h2A, 3'h4, 40'h0E03010100, 2'h2, 24'h8E2A00},
    {3'h4, 6'h2A, 3'h4, 40'h0E05010100, 2'h2, 24'h8E1700},
    {3'h4, 6'h2A, 3'h4, 40'h0E01000100, 2'h2, 24'h8E0100},
    {3'h4, 6'h2A, 3'h4, 40'h3301010300, 2'h3, 24'h9408FF},
    {3'h4, 6'h2A, 3'h4, 40'h0E20010300, 2'h3, 24'h9416FF},
    {3'h4, 6'h2A, 3'h4, 40'h0E01010700, 2'h3, 24'h9414FF},
    {3'h4, 6'h2A, 3'h5, 40'h1064010300, 2'h3, 24'h9409FF},
    {3'h4, 6'h2A, 3'h5, 40'h1064010304, 2'h1, 24'h900000},
    {3'h4, 6'h2A, 3'h4, 40'h0E64010300, 2'h2, 24'h8E0400},
    {3'h4, 6'h2A, 3'h5, 40'h10650103FF, 2'h1, 24'h900000},
    {3'h4, 6'h2A, 3'h4, 40'h0E65010300, 2'h2, 24'h8EFF00},
    {3'h4, 6'h15, 3'h4, 40'h0E01010300, 2'h0, 24'h0},
    {3'h6, 6'h15, 3'h4, 40'h4B03011700, 2'h0, 24'h0},
    {3'h3, 6'h2A, 3'h4, 40'h0E01010300, 2'h0, 24'h0},
    {3'h7, 6'h2A, 3'h0, 40'h0, 2'h0, 24'h0}};
  dn_link_if lnk ();
  dn_slave_end u_dn_slave_end (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk),
    .node_addr(6'h2A), .product_code(16'hA5C3), .prod_wr(prod_wr), .prod_addr(prod_addr),
    .prod_wdata(prod_wdata), .cos_trig(cos_trig), .cons_valid(cons_valid),
    .cons_ready(cons_ready), .cons_data(cons_data), .dup_detect(dup_detect),
    .alloc_state(alloc_state));
  dn_master_end u_dn_master_end (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_node(tx_node), .tx_code(tx_code),
    .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid), .rx_ready(1'b1),
    .rx_id(rx_id), .rx_data(rx_data), .rx_last(rx_last));
  dn_link_checker u_dn_link_checker (.ref_clk(ref_clk), .rst_n(rst_n), .node_addr(6'h2A),
    .m2s_valid(lnk.m2s_valid), .m2s_ready(lnk.m2s_ready), .m2s_id(lnk.m2s_id),
    .m2s_data(lnk.m2s_data), .m2s_last(lnk.m2s_last), .s2m_valid(lnk.s2m_valid),
    .s2m_ready(lnk.s2m_ready), .s2m_id(lnk.s2m_id), .s2m_data(lnk.s2m_data),
    .s2m_last(lnk.s2m_last));
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) rxq.push_back({rx_last, rx_id, rx_data});
    if (cons_valid === 1'b1 && cons_ready === 1'b1) consq.push_back(cons_data);
  end
  task automatic tally_and_finish();
    $display("errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send_frame(input logic [2:0] code, input logic [5:0] nd, input int n,
                            input logic [47:0] d);
    for (int i = 0; i < n; i++) begin
      tx_valid = 1; tx_code = code; tx_node = nd; tx_data = d[47-8*i -: 8]; tx_last = i == n-1;
      while (tx_ready !== 1'b1) begin @(posedge ref_clk); #1; end
      @(posedge ref_clk); #1;
    end
    tx_valid = 0;
    tx_last = 0;
    @(posedge ref_clk); #1;
  endtask
  // i/o answers carry the produced image, written as index xor 5A
  task automatic get_rx(input logic [10:0] id, input int cnt, input logic [31:0] rsp);
    logic [7:0] e;
    logic [19:0] got;
    repeat (12) @(posedge ref_clk);
    for (int k = 0; k < 3000 && rxq.size() < cnt; k++) @(posedge ref_clk);
    `CHK(rxq.size(), cnt)
    for (int k = 0; k < cnt && rxq.size() > 0; k++) begin
      e = id[10] ? rsp[31-8*k -: 8] : 8'(k) ^ 8'h5A;
      got = rxq.pop_front();
      `CHK(got, {k == cnt-1, id, e})
    end
  endtask
  task automatic run_row(input row_t r);
    send_frame(r.code, r.nd, int'(r.n) + 1, {8'h05, r.req});
    get_rx(11'h553, (r.m == 0) ? 0 : int'(r.m) + 1, {8'h05, r.rsp});
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rst_n = 0; prod_wr = 0; prod_addr = 0; prod_wdata = 0; cos_trig = 0; cons_ready = 0;
    tx_valid = 0; tx_last = 0; tx_data = 0; tx_node = 0; tx_code = 0;
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(alloc_state, 8'h00)
    `CHK(dup_detect, 1'b0)
    for (int a = 0; a < 255; a++) begin
      prod_wr = 1; prod_addr = 8'(a); prod_wdata = 8'(a) ^ 8'h5A;
      @(posedge ref_clk); #1;
    end
    prod_wr = 0;
    foreach (rows[i]) run_row(rows[i]);
    `CHK(dup_detect, 1'b1)
    `CHK(alloc_state, 8'h17)
    send_frame(3'h0, 6'h01, 1, 48'h05);
    get_rx(11'h3AA, 255, 0);
    // consumer stalls so the fifo fills and the fifth poll is held off
    fork
      for (int p = 0; p < 5; p++) begin
        send_frame(3'h5, 6'h2A, (p == 0) ? 6 : 4, 48'h101010101010 * p + 48'h000102030405);
        get_rx(11'h3EA, 255, 0);
        pc++;
      end
    join_none
    for (int k = 0; k < 6000 && !(pc == 4 && lnk.m2s_valid === 1'b1); k++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    #1;
    `CHK(lnk.m2s_ready, 1'b0)
    `CHK(cons_valid, 1'b1)
    cons_ready = 1;
    for (int k = 0; k < 6000 && pc < 5; k++) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk); #1;
    `CHK(consq.size(), 20)
    for (int i = 0; i < 20 && i < consq.size(); i++) `CHK(consq[i], {4'(i/4), 4'(i%4)})
    `CHK(cons_valid, 1'b0)
    cos_trig = 1;
    @(posedge ref_clk);
    #1 cos_trig = 0;
    get_rx(11'h36A, 255, 0);
    run_row({3'h6, 6'h2A, 3'h4, 40'h4C03011700, 2'h2, 24'hCC0000});
    run_row(rows[0]);
    `CHK(alloc_state, 8'h00)
    #1 rst_n = 0;
    @(posedge ref_clk);
    #1;
    `CHK(dup_detect, 1'b0)
    rst_n = 1;
    repeat (2) @(posedge ref_clk); #1 `CHK(lnk.m2s_ready, 1'b1)
    tally_and_finish();
  end
endmodule
`default_nettype wire
